/* core/rvq_pkg.sv */
`default_nettype none

package rvq_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_CTRL_A = 6'h16;  // Report delay low, max time
    localparam logic [5:0] IDX_CTRL_B = 6'h17;  // Delay bit 2, timeout, confirm
    localparam logic [5:0] IDX_CTRL_C = 6'h18;  // Enable, assertion time
    localparam logic [5:0] IDX_RSVD_LO = 6'h19; // First reserved register
    localparam logic [5:0] IDX_RSVD_HI = 6'h1c; // Last reserved register
    localparam logic [5:0] IDX_LINE_V = 6'h1d;  // Line voltage status
    localparam logic [5:0] IDX_IRQ_STS = 6'h1e; // Sticky event status
    localparam logic [5:0] IDX_IRQ_MSK = 6'h1f; // Event mask

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CTRL_A = 8'h00;
    localparam logic [7:0] RST_CTRL_B = 8'h2d;
    localparam logic [7:0] RST_CTRL_C = 8'h19;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int DLY_LO_MSB = 7;  // Control A: report delay bits 1:0
    localparam int DLY_LO_LSB = 6;
    localparam int MAXT_MSB = 5;    // Control A: max time field
    localparam int DLY_HI_BIT = 7;  // Control B: report delay bit 2
    localparam int TMO_MSB = 6;     // Control B: end timeout code
    localparam int TMO_LSB = 3;
    localparam int CONF_MSB = 2;    // Control B: confirm interval code
    localparam int ENA_BIT = 7;     // Control C: qualify enable
    localparam int ASRT_MSB = 5;    // Control C: assertion time field
    localparam int LV_MSB = 6;      // Line voltage field
    localparam int EV_VALID = 0;    // Status: ring became valid
    localparam int EV_END = 1;      // Status: ringing finished
    localparam int EV_BAD = 2;      // Status: ring invalidated

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 100;       // Clock period in ns
    localparam int TICK_US = 1000;     // Base tick in us
    localparam int TICK_CYC = (TICK_US * 1000) / CLK_NS;
    localparam logic [10:0] TMO_STEP_MS = 11'h080;  // Timeout step, 128 ms
    // Confirm interval per code, in ms
    localparam logic [10:0] CONF_MS_0 = 11'h064;
    localparam logic [10:0] CONF_MS_1 = 11'h096;
    localparam logic [10:0] CONF_MS_2 = 11'h0c8;
    localparam logic [10:0] CONF_MS_3 = 11'h100;
    localparam logic [10:0] CONF_MS_4 = 11'h180;
    localparam logic [10:0] CONF_MS_5 = 11'h200;
    localparam logic [10:0] CONF_MS_6 = 11'h280;
    localparam logic [10:0] CONF_MS_7 = 11'h400;
    // Report delay per code, in ms
    localparam logic [10:0] DLY_MS_NONE = 11'h000;
    localparam logic [10:0] DLY_MS_1 = 11'h100;
    localparam logic [10:0] DLY_MS_2 = 11'h200;
    localparam logic [10:0] DLY_MS_7 = 11'h700;

    // Qualifier states
    typedef enum logic [1:0] {
        RVQ_IDLE = 2'b00,
        RVQ_QUAL = 2'b01,
        RVQ_DELAY = 2'b10,
        RVQ_VALID = 2'b11
    } rvq_state_t;

endpackage

`default_nettype wire

/* core/rvq_ring_qualifier.sv */
// Operation
// RL1: Programmable delay before reporting validated ring.
// RL2: Ringing ends after timeout code times 128ms.
// RL3: Ring must stay in tolerance for confirm interval.
// RL4: Validation applies only while enable bit set.
// RL5: Each event reloads timer with assertion time.
// RL6: Event after timer expiry means frequency too low.
// RL7: Event while timer exceeds max means too high.
// RL8: Assertion minus max sets shortest event spacing.
// RL9: Software sets assertion time for lowest frequency.
// RL10: Software writes zero to reserved bits.
// RL11: Line voltage read back, one volt per LSB.
// RL12: Disabled validation passes detections straight through.
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module rvq_ring_qualifier #(
    parameter int unsigned TICK_CYC = rvq_pkg::TICK_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic ring_event_i,
    input wire logic [6:0] line_volts_i,
    output logic ring_valid_o,
    output logic irq_o
);

    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    typedef struct packed {
        rvq_pkg::rvq_state_t state; // Qualifier state
        logic [13:0] tick_cnt;      // Clock divider for 1 ms tick
        logic ms_tick;              // One-cycle 1 ms strobe
        logic half;                 // Halves tick rate to 2 ms
        logic [5:0] qtmr;           // Qualification down-counter
        logic [10:0] elapsed;       // ms since QUAL or DELAY entry
        logic [10:0] quiet;         // ms since last event
        logic [7:0] ctrl_a;         // Control A
        logic [7:0] ctrl_b;         // Control B
        logic [7:0] ctrl_c;         // Control C
        logic [2:0] sts;            // Sticky event flags
        logic [2:0] msk;            // Event mask
        logic ack;                  // Bus acknowledge
        logic [31:0] dat;           // Bus read data
        logic valid;                // Ring valid indication
        logic irq;                  // Interrupt line
    } rvq_regs_t;

    rvq_regs_t r_ff;     // Registered state
    rvq_regs_t nxt_r;    // Next state

    // Decoded fields
    logic ena;
    logic [5:0] asrt_time;
    logic [5:0] max_time;
    logic [3:0] tmo_code;
    logic [2:0] dly_code;
    logic [10:0] conf_ms;
    logic [10:0] dly_ms;
    logic [10:0] tmo_ms;
    logic [5:0] idx;
    logic bus_req;
    logic wr_b0;
    logic [2:0] ev;

    assign ena = r_ff.ctrl_c[rvq_pkg::ENA_BIT];
    assign asrt_time = r_ff.ctrl_c[rvq_pkg::ASRT_MSB:0];
    assign max_time = r_ff.ctrl_a[rvq_pkg::MAXT_MSB:0];
    assign tmo_code = r_ff.ctrl_b[rvq_pkg::TMO_MSB:rvq_pkg::TMO_LSB];
    assign dly_code = {r_ff.ctrl_b[rvq_pkg::DLY_HI_BIT],
                       r_ff.ctrl_a[rvq_pkg::DLY_LO_MSB:rvq_pkg::DLY_LO_LSB]};
    assign idx = wb_adr_i[7:2];
    assign bus_req = wb_cyc_i && wb_stb_i && !r_ff.ack;
    assign wr_b0 = bus_req && wb_we_i && wb_sel_i[0];

    // ------------------------------------------------------------
    // Interval lookups
    // ------------------------------------------------------------
    // Confirm interval per code
    always_comb begin
        case (r_ff.ctrl_b[rvq_pkg::CONF_MSB:0])
            3'h0: conf_ms = rvq_pkg::CONF_MS_0;
            3'h1: conf_ms = rvq_pkg::CONF_MS_1;
            3'h2: conf_ms = rvq_pkg::CONF_MS_2;
            3'h3: conf_ms = rvq_pkg::CONF_MS_3;
            3'h4: conf_ms = rvq_pkg::CONF_MS_4;
            3'h5: conf_ms = rvq_pkg::CONF_MS_5;
            3'h6: conf_ms = rvq_pkg::CONF_MS_6;
            default: conf_ms = rvq_pkg::CONF_MS_7;
        endcase
    end

    // Report delay per code; undefined codes give no delay
    always_comb begin
        case (dly_code)
            3'h1: dly_ms = rvq_pkg::DLY_MS_1;
            3'h2: dly_ms = rvq_pkg::DLY_MS_2;
            3'h7: dly_ms = rvq_pkg::DLY_MS_7;
            default: dly_ms = rvq_pkg::DLY_MS_NONE;
        endcase
    end

    // Timeout limit; the illegal code zero acts as code one
    always_comb begin
        if (tmo_code == 4'h0) begin
            tmo_ms = rvq_pkg::TMO_STEP_MS;
        end else begin
            tmo_ms = {tmo_code, 7'h00};
        end
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        nxt_r = r_ff;
        ev = 3'h0;

        // Millisecond tick, 2 ms sub-rate
        nxt_r.ms_tick = 1'b0;
        if (r_ff.tick_cnt == 14'(TICK_CYC - 1)) begin
            nxt_r.tick_cnt = 14'h0000;
            nxt_r.ms_tick = 1'b1;
        end else begin
            nxt_r.tick_cnt = r_ff.tick_cnt + 14'h0001;
        end
        if (r_ff.ms_tick) begin
            nxt_r.half = !r_ff.half;
            if (r_ff.elapsed != 11'h7ff) begin
                nxt_r.elapsed = r_ff.elapsed + 11'h001;
            end
            if (r_ff.quiet != 11'h7ff) begin
                nxt_r.quiet = r_ff.quiet + 11'h001;
            end
        end
        // RL5: timer decrements at 2 ms
        if (r_ff.ms_tick && r_ff.half && r_ff.qtmr != 6'h00) begin
            nxt_r.qtmr = r_ff.qtmr - 6'h01;
        end
        if (ring_event_i) begin
            nxt_r.quiet = 11'h000;
        end

        if (!ena) begin
            // RL4: qualifier idle when disabled
            nxt_r.state = rvq_pkg::RVQ_IDLE;
            // RL12: direct pass, timers cleared
            nxt_r.qtmr = 6'h00;
            nxt_r.elapsed = 11'h000;
            nxt_r.quiet = 11'h000;
            nxt_r.valid = ring_event_i;
            if (ring_event_i && !r_ff.valid) begin
                ev[rvq_pkg::EV_VALID] = 1'b1;
            end
        end else begin
            case (r_ff.state)
                rvq_pkg::RVQ_IDLE: begin
                    nxt_r.valid = 1'b0;
                    if (ring_event_i) begin
                        // RL5: first event loads timer
                        nxt_r.state = rvq_pkg::RVQ_QUAL;
                        nxt_r.qtmr = asrt_time;
                        nxt_r.elapsed = 11'h000;
                        nxt_r.half = 1'b0;
                    end
                end
                rvq_pkg::RVQ_QUAL: begin
                    if (ring_event_i) begin
                        if (r_ff.qtmr == 6'h00) begin
                            // RL6: too low, invalidate
                            nxt_r.state = rvq_pkg::RVQ_IDLE;
                            ev[rvq_pkg::EV_BAD] = 1'b1;
                        end else if (r_ff.qtmr > max_time) begin
                            // RL7: too high; RL8 min spacing
                            nxt_r.state = rvq_pkg::RVQ_IDLE;
                            ev[rvq_pkg::EV_BAD] = 1'b1;
                        end else begin
                            // RL5: reload on accepted event
                            nxt_r.qtmr = asrt_time;
                            nxt_r.half = 1'b0;
                        end
                    end else if (r_ff.quiet >= tmo_ms) begin
                        // RL2: ring stopped before confirm
                        nxt_r.state = rvq_pkg::RVQ_IDLE;
                    end else if (r_ff.elapsed >= conf_ms) begin
                        // RL3: confirm interval met
                        nxt_r.state = rvq_pkg::RVQ_DELAY;
                        nxt_r.elapsed = 11'h000;
                    end
                end
                rvq_pkg::RVQ_DELAY: begin
                    if (!ring_event_i && r_ff.quiet >= tmo_ms) begin
                        // RL2: ring ended during delay
                        nxt_r.state = rvq_pkg::RVQ_IDLE;
                    end else if (r_ff.elapsed >= dly_ms) begin
                        // RL1: report after delay
                        nxt_r.state = rvq_pkg::RVQ_VALID;
                        nxt_r.valid = 1'b1;
                        ev[rvq_pkg::EV_VALID] = 1'b1;
                    end
                end
                default: begin
                    if (!ring_event_i && r_ff.quiet >= tmo_ms) begin
                        // RL2: ringing finished
                        nxt_r.state = rvq_pkg::RVQ_IDLE;
                        nxt_r.valid = 1'b0;
                        ev[rvq_pkg::EV_END] = 1'b1;
                    end
                end
            endcase
        end

        // Register writes, low byte lane only
        nxt_r.ack = bus_req;
        if (wr_b0) begin
            if (idx == rvq_pkg::IDX_CTRL_A) begin
                nxt_r.ctrl_a = wb_dat_i[7:0];
            end else if (idx == rvq_pkg::IDX_CTRL_B) begin
                nxt_r.ctrl_b = wb_dat_i[7:0];
            end else if (idx == rvq_pkg::IDX_CTRL_C) begin
                nxt_r.ctrl_c = {wb_dat_i[7], 1'b0, wb_dat_i[5:0]};
            end else if (idx == rvq_pkg::IDX_IRQ_MSK) begin
                nxt_r.msk = wb_dat_i[2:0];
            end
        end

        // Sticky flags: write one clears, new event wins
        if (wr_b0 && idx == rvq_pkg::IDX_IRQ_STS) begin
            nxt_r.sts = (r_ff.sts & ~wb_dat_i[2:0]) | ev;
        end else begin
            nxt_r.sts = r_ff.sts | ev;
        end
        nxt_r.irq = |(nxt_r.sts & nxt_r.msk);

        // Read data; unmapped and reserved read zero
        nxt_r.dat = 32'h0000_0000;
        if (bus_req && !wb_we_i) begin
            if (idx == rvq_pkg::IDX_CTRL_A) begin
                nxt_r.dat[7:0] = r_ff.ctrl_a;
            end else if (idx == rvq_pkg::IDX_CTRL_B) begin
                nxt_r.dat[7:0] = r_ff.ctrl_b;
            end else if (idx == rvq_pkg::IDX_CTRL_C) begin
                nxt_r.dat[7:0] = r_ff.ctrl_c;
            end else if (idx == rvq_pkg::IDX_LINE_V) begin
                // RL11: line voltage, 1 V per LSB
                nxt_r.dat[rvq_pkg::LV_MSB:0] = line_volts_i;
            end else if (idx == rvq_pkg::IDX_IRQ_STS) begin
                nxt_r.dat[2:0] = r_ff.sts;
            end else if (idx == rvq_pkg::IDX_IRQ_MSK) begin
                nxt_r.dat[2:0] = r_ff.msk;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r_ff <= '0;
            r_ff.state <= rvq_pkg::RVQ_IDLE;
            r_ff.ctrl_a <= rvq_pkg::RST_CTRL_A;
            r_ff.ctrl_b <= rvq_pkg::RST_CTRL_B;
            r_ff.ctrl_c <= rvq_pkg::RST_CTRL_C;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign wb_dat_o = r_ff.dat;
    assign wb_ack_o = r_ff.ack;
    assign ring_valid_o = r_ff.valid;
    assign irq_o = r_ff.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_disabled_pass: assert property ( // RL12
        @(posedge clk_i) disable iff (rst_i)
        !ena && !wb_cyc_i |=> ring_valid_o == $past(ring_event_i))
        else $error("disabled pass-through wrong");

    a_enable_gate: assert property ( // RL4
        @(posedge clk_i) disable iff (rst_i)
        !ena |=> r_ff.state == rvq_pkg::RVQ_IDLE)
        else $error("qualifier active while disabled");

    a_timer_reload: assert property ( // RL5
        @(posedge clk_i) disable iff (rst_i)
        ena && !wb_cyc_i && r_ff.state == rvq_pkg::RVQ_IDLE && ring_event_i
        |=> r_ff.qtmr == $past(asrt_time))
        else $error("timer not loaded on event");

    a_low_freq: assert property ( // RL6
        @(posedge clk_i) disable iff (rst_i)
        ena && !wb_cyc_i && r_ff.state == rvq_pkg::RVQ_QUAL
        && ring_event_i && r_ff.qtmr == 6'h00
        |=> r_ff.state == rvq_pkg::RVQ_IDLE && r_ff.sts[2])
        else $error("slow ring not rejected");

    a_high_freq: assert property ( // RL7
        @(posedge clk_i) disable iff (rst_i)
        ena && !wb_cyc_i && r_ff.state == rvq_pkg::RVQ_QUAL
        && ring_event_i && r_ff.qtmr > max_time
        |=> r_ff.state == rvq_pkg::RVQ_IDLE)
        else $error("fast ring not rejected");

    a_confirm_move: assert property ( // RL3
        @(posedge clk_i) disable iff (rst_i)
        ena && !wb_cyc_i && r_ff.state == rvq_pkg::RVQ_QUAL && !ring_event_i
        && r_ff.quiet < tmo_ms && r_ff.elapsed >= conf_ms
        |=> r_ff.state == rvq_pkg::RVQ_DELAY && r_ff.elapsed == 11'h000)
        else $error("confirm interval not honoured");

    a_delay_report: assert property ( // RL1
        @(posedge clk_i) disable iff (rst_i)
        ena && !wb_cyc_i && r_ff.state == rvq_pkg::RVQ_DELAY
        && r_ff.quiet < tmo_ms && r_ff.elapsed < dly_ms
        |=> !ring_valid_o)
        else $error("ring reported before delay");

    // Once the delay has run out the ring must be reported and flagged
    a_delay_done: assert property ( // RL1
        @(posedge clk_i) disable iff (rst_i)
        ena && !wb_cyc_i && r_ff.state == rvq_pkg::RVQ_DELAY
        && (ring_event_i || r_ff.quiet < tmo_ms) && r_ff.elapsed >= dly_ms
        |=> ring_valid_o && r_ff.sts[rvq_pkg::EV_VALID])
        else $error("valid ring not reported after delay");

    a_ring_end: assert property ( // RL2
        @(posedge clk_i) disable iff (rst_i)
        ena && !wb_cyc_i && r_ff.state == rvq_pkg::RVQ_VALID
        && !ring_event_i && r_ff.quiet >= tmo_ms
        |=> !ring_valid_o ##1 !ring_valid_o)
        else $error("ringing end not detected");

    // An invalidation sets its flag even against a same-cycle clear
    a_bad_sticky: assert property ( // RL6
        @(posedge clk_i) disable iff (rst_i)
        ev[rvq_pkg::EV_BAD] |=> r_ff.sts[rvq_pkg::EV_BAD])
        else $error("invalidation status not set");

    a_volts_read: assert property ( // RL11
        @(posedge clk_i) disable iff (rst_i)
        bus_req && !wb_we_i && idx == rvq_pkg::IDX_LINE_V
        |=> wb_ack_o && wb_dat_o == {25'h0, $past(line_volts_i)})
        else $error("line voltage read wrong");

endmodule

`default_nettype wire

/* verif/ring_validation_qualifier_test.sv */
`timescale 1ns/1ps
`default_nettype none

module ring_validation_qualifier_test;
    // ------------------------------------------------------------
    // Signals and tables
    // ------------------------------------------------------------
    localparam int TK = 10; // Cycles per 1 ms tick
    typedef struct packed {
        logic [7:0] adr;
        logic [6:0] volts;
        logic [7:0] exp;
    } rvq_rd_row_t;
    typedef struct packed {
        logic [2:0] dly;
        logic [2:0] conf;
        logic [3:0] tmo;
        int ms;
        int end_ms;
    } rvq_tm_row_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [6:0] line_volts_i = 7'h00;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic ring_event_i;
    logic ring_valid_o;
    logic irq_o;
    logic run = 1'b0; // Ring line active
    logic [15:0] gap = 16'h00fa; // Crossing spacing in cycles
    int errors = 0;
    int total_checks = 0;
    int cyc = 0;
    int last_ev = 0; // Cycle of the latest crossing
    // Reset values and read-back, unmapped index last
    rvq_rd_row_t rd_rows [10] = '{'{8'h58, 7'h00, 8'h00},
        '{8'h5c, 7'h00, 8'h2d}, '{8'h60, 7'h00, 8'h19},
        '{8'h64, 7'h00, 8'h00}, '{8'h70, 7'h00, 8'h00},
        '{8'h74, 7'h7f, 8'h7f}, '{8'h74, 7'h01, 8'h01},
        '{8'h78, 7'h00, 8'h00}, '{8'h7c, 7'h00, 8'h00},
        '{8'h00, 7'h00, 8'h00}};
    // Delay, confirm, timeout codes with expected ms figures
    rvq_tm_row_t tm_rows [4] = '{'{3'h0, 3'h0, 4'h1, 100, 128},
        '{3'h1, 3'h3, 4'h2, 512, 256}, '{3'h2, 3'h4, 4'h3, 896, 384},
        '{3'h7, 3'h7, 4'h1, 2816, 128}};
    logic [15:0] bad_gaps [2] = '{16'h01c2, 16'h0096}; // 45 ms, 15 ms

    rvq_ring_qualifier #(.TICK_CYC(TK)) rvq_ring_qualifier_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .ring_event_i(ring_event_i),
        .line_volts_i(line_volts_i), .ring_valid_o(ring_valid_o),
        .irq_o(irq_o));
    rvq_ring_source rvq_ring_source_inst (.clk_i(clk_i), .rst_i(rst_i),
        .run_i(run), .gap_i(gap), .ring_event_o(ring_event_i));

    // 100 ns clock
    initial begin
        forever #50 clk_i = ~clk_i;
    end

    // Cycle count and latest crossing
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (ring_event_i === 1'b1) last_ev <= cyc;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
        total_checks++;
        if (got !== ex) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic rng(string nm, int lo, int hi, int got);
        total_checks++;
        if (got < lo || got > hi) begin
            errors++;
            $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask

    // Classic Wishbone cycle, entered just after a rising edge
    task automatic wb(logic we, logic [7:0] adr, logic [7:0] dat,
                      output logic [31:0] rd);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h000000, dat};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (n >= 50) chk("wb_ack", 32'h1, 32'h0);
        @(posedge clk_i);
    endtask

    task automatic wr(logic [7:0] adr, logic [7:0] dat);
        logic [31:0] d;
        wb(1'b1, adr, dat, d);
    endtask

    task automatic rd_chk(string nm, logic [7:0] adr, logic [7:0] ex);
        logic [31:0] d;
        wb(1'b0, adr, 8'h00, d);
        chk(nm, {24'h000000, ex}, d);
    endtask

    // Cycles until the valid indication reaches lvl, bounded
    task automatic wait_lvl(logic lvl, int lim, output int n);
        n = 0;
        while (ring_valid_o !== lvl && n < lim) begin
            @(posedge clk_i);
            n++;
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int n;
        rvq_tm_row_t r;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wr(8'h64, 8'h00);
        foreach (rd_rows[i]) begin
            line_volts_i <= rd_rows[i].volts;
            rd_chk("reg_read", rd_rows[i].adr, rd_rows[i].exp);
        end
        foreach (tm_rows[i]) begin
            r = tm_rows[i];
            wr(8'h58, {r.dly[1:0], 6'h0a});
            wr(8'h5c, {r.dly[2], r.tmo, r.conf});
            wr(8'h60, 8'h94);
            gap <= 16'h00fa;
            run <= 1'b1;
            wait_lvl(1'b1, (r.ms + 20) * TK, n);
            rng("valid_ms", r.ms - 2, r.ms + 3, n / TK);
            run <= 1'b0;
            wait_lvl(1'b0, (r.end_ms + 40) * TK, n);
            n = (cyc - last_ev) / TK;
            rng("end_ms", r.end_ms - 2, r.end_ms + 3, n);
            rd_chk("sts_ring", 8'h78, 8'h03);
            wr(8'h78, 8'h07);
        end
        // Crossings too slow, then too fast, never give a valid ring
        wr(8'h58, 8'h0a);
        wr(8'h5c, 8'h08);
        foreach (bad_gaps[i]) begin
            gap <= bad_gaps[i];
            run <= 1'b1;
            // Valid must not rise at any point of the burst
            wait_lvl(1'b1, 1500, n);
            run <= 1'b0;
            chk("no_valid", 32'h0000_05dc, n);
            repeat (2000) @(posedge clk_i);
            rd_chk("sts_bad", 8'h78, 8'h04);
            wr(8'h78, 8'h07);
        end
        // Disabled: single crossing passes straight through
        wr(8'h60, 8'h14);
        gap <= 16'hffff;
        run <= 1'b1;
        @(posedge clk_i);
        run <= 1'b0;
        wait_lvl(1'b1, 10, n);
        rng("pass_lat", 1, 4, n);
        @(posedge clk_i);
        chk("pass_len", 32'h0, {31'h0, ring_valid_o});
        // Interrupt raised by mask, cleared by writing one
        wr(8'h7c, 8'h01);
        repeat (2) @(posedge clk_i);
        chk("irq_set", 32'h1, {31'h0, irq_o});
        wr(8'h78, 8'h01);
        repeat (2) @(posedge clk_i);
        chk("irq_clr", 32'h0, {31'h0, irq_o});
        // Reset in mid-ring drops the indication and reloads registers
        wr(8'h60, 8'h94);
        gap <= 16'h00fa;
        run <= 1'b1;
        wait_lvl(1'b1, 1200, n);
        rng("pre_rst_ms", 98, 103, n / TK);
        chk("irq_ring", 32'h1, {31'h0, irq_o});
        rst_i <= 1'b1;
        run <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk("rst_valid", 32'h0, {31'h0, ring_valid_o});
        chk("rst_irq", 32'h0, {31'h0, irq_o});
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd_chk("rst_ctrl_c", 8'h60, 8'h19);
        rd_chk("rst_msk", 8'h7c, 8'h00);
        close_out();
    end

    // Watchdog: about 61000 cycles expected, limit kept under 100000
    initial begin
        repeat (90000) @(posedge clk_i);
        errors++;
        close_out();
    end
endmodule

`default_nettype wire

/* verif/rvq_ring_source.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Ring line model
// ------------------------------------------------------------
// Threshold crossings arrive as one-cycle pulses, gap_i cycles
// apart. The line is quiet while run_i is low.
module rvq_ring_source (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic [15:0] gap_i,
    output logic ring_event_o
);
    logic [15:0] cnt_ff; // Cycles since the last crossing

    // First crossing on the edge after run_i rises, then periodic
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            cnt_ff <= 16'h0000;
            ring_event_o <= 1'b0;
        end else begin
            ring_event_o <= (cnt_ff == 16'h0000);
            if (cnt_ff == gap_i - 16'h0001) begin
                cnt_ff <= 16'h0000;
            end else begin
                cnt_ff <= cnt_ff + 16'h0001;
            end
        end
    end
endmodule

`default_nettype wire
